/* File: edge_flag.v */
// One change-detect flag: sticky, cleared on status read, set beats clear
`timescale 1ns/10ps
module edge_flag #(
    parameter FALL_ONLY = 0
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Observed level and read clear
    input wire level,
    input wire read_clear,
    // Sticky flag
    output reg flag
);
    reg last;
    wire hit;

    // Falling edge only, or any change
    assign hit = FALL_ONLY ? (last & ~level) : (last ^ level);

    // Set wins so an edge in the read cycle is reported next time
    always @(posedge clk) begin
        if (srst) begin
            last <= 1'b0;
            flag <= 1'b0;
        end else begin
            last <= level;
            if (hit)
                flag <= 1'b1;
            else if (read_clear)
                flag <= 1'b0;
        end
    end
endmodule

/* File: host_bus_model.sv */
// Host processor model driving the parallel register port
`timescale 1ns/10ps
module host_bus_model (
    // Clock
    input wire clk,
    // Strobes, address and write data
    output reg [2:0] addr,
    output reg wr_en,
    output reg rd_en,
    output reg [7:0] wr_data
);
    // One strobe cycle; released lines invert so stale data never matches
    task access(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wr_data, wr_en, rd_en} = {a, d, w, !w};
        @(negedge clk);
        {addr, wr_data, wr_en, rd_en} = {~a, ~d, 2'b00};
    endtask
    initial {addr, wr_data, wr_en, rd_en} = 13'h0000;
endmodule

/* File: modem_host_port.v */
// Modem status, scratch and divisor registers of the parallel host port
`timescale 1ns/10ps
`include "modem_regs_map.vh"
// Register map as the host sees it, framing bit 7 selecting the bank:
//   0  divisor low byte (bank 1), otherwise reads zero
//   1  divisor high byte (bank 1), otherwise reads zero
//   2  interrupt identify, read only, bit 0 low while a delta is set
//   3  framing control, always reachable
//   4  line control outputs (bank 0 only): DTR, RTS, two user outputs
//      and the loopback bit; the upper three bits read back as zero
//   5  unmapped, reads zero and ignores writes
//   6  line status inputs: four levels over four sticky delta flags
//   7  scratch byte, plain storage with no side effect
// The divisor is kept for software compatibility only; nothing here
// counts with it, so any value written is harmless.
// Status reads clear the deltas, but an edge landing in the read cycle
// still sets its flag, so software never loses a transition.
module modem_host_port (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Host register port
    input wire [2:0] addr,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    // External modem inputs, asynchronous
    input wire dcd_in,
    input wire ri_in,
    input wire dsr_in,
    input wire cts_in,
    // Modem control outputs
    output reg dtr_out,
    output reg rts_out,
    output reg user_output_one,
    output reg user_output_two,
    // Modem status interrupt request
    output reg modem_irq
);
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg [7:0] scratch_byte;
    reg [7:0] divisor_low_byte;
    reg [7:0] divisor_high_byte;
    reg [7:0] framing_control;
    reg [`CTRL_WIDTH-1:0] line_control_outputs;
    reg [3:0] levels;
    reg [7:0] next_rd_data;
    wire [3:0] deltas;
    wire div_access;
    wire status_read;

    assign div_access = framing_control[`FRAMING_DIV_ACCESS];
    assign status_read = rd_en & (addr == `ADDR_STATUS);

    // Two-stage synchronisers, order DCD RI DSR CTS
    always @(posedge clk) begin
        if (srst) begin
            sync1 <= `RESET_INPUTS;
            sync2 <= `RESET_INPUTS;
        end else begin
            sync1 <= {dcd_in, ri_in, dsr_in, cts_in};
            sync2 <= sync1;
        end
    end

    // Level source: loopback uses null-modem crossing of control bits
    always @* begin
        if (line_control_outputs[`CTRL_LOOPBACK]) begin
            levels[3] = line_control_outputs[`CTRL_USER_TWO];
            levels[2] = line_control_outputs[`CTRL_USER_ONE];
            levels[1] = line_control_outputs[`CTRL_DTR];
            levels[0] = line_control_outputs[`CTRL_RTS];
        end else begin
            // Synchronised pins, same bit order as the status nibble
            levels[3] = sync2[3];
            levels[2] = sync2[2];
            levels[1] = sync2[1];
            levels[0] = sync2[0];
        end
    end

    // Change flags: DCD, RI trailing edge, DSR, CTS
    edge_flag #(
        .FALL_ONLY(0)
    ) dcd_flag (
        .clk(clk),
        .srst(srst),
        .level(levels[3]),
        .read_clear(status_read),
        .flag(deltas[3])
    );

    // Ring only reports the end of a ring, not its start
    edge_flag #(
        .FALL_ONLY(1)
    ) ri_flag (
        .clk(clk),
        .srst(srst),
        .level(levels[2]),
        .read_clear(status_read),
        .flag(deltas[2])
    );

    edge_flag #(
        .FALL_ONLY(0)
    ) dsr_flag (
        .clk(clk),
        .srst(srst),
        .level(levels[1]),
        .read_clear(status_read),
        .flag(deltas[1])
    );

    edge_flag #(
        .FALL_ONLY(0)
    ) cts_flag (
        .clk(clk),
        .srst(srst),
        .level(levels[0]),
        .read_clear(status_read),
        .flag(deltas[0])
    );

    // Low divisor byte: storage only, no baud clock derived from it
    always @(posedge clk) begin
        if (srst) begin
            divisor_low_byte <= `RESET_BYTE;
        end else if (wr_en && addr == `ADDR_DIV_LOW && div_access) begin
            divisor_low_byte <= wr_data;
        end
    end

    // High divisor byte, shares its address with nothing in bank 1
    always @(posedge clk) begin
        if (srst) begin
            divisor_high_byte <= `RESET_BYTE;
        end else if (wr_en && addr == `ADDR_DIV_HIGH && div_access) begin
            divisor_high_byte <= wr_data;
        end
    end

    // Framing control stays reachable so software can leave bank 1
    always @(posedge clk) begin
        if (srst) begin
            framing_control <= `RESET_BYTE;
        end else if (wr_en && addr == `ADDR_FRAMING) begin
            framing_control <= wr_data;
        end
    end

    // Control bits; upper bits are reserved and stay zero
    always @(posedge clk) begin
        if (srst) begin
            line_control_outputs <= `RESET_CTRL;
        end else if (wr_en && addr == `ADDR_LINE_CTRL && !div_access) begin
            line_control_outputs <= wr_data[`CTRL_WIDTH-1:0];
        end
    end

    // Scratch byte, no side effect on any other logic
    always @(posedge clk) begin
        if (srst) begin
            scratch_byte <= `RESET_BYTE;
        end else if (wr_en && addr == `ADDR_SCRATCH) begin
            scratch_byte <= wr_data;
        end
    end

    // Read mux; unmapped or hidden addresses read zero
    always @* begin
        next_rd_data = 8'h00;
        if (addr == `ADDR_DIV_LOW && div_access) begin
            next_rd_data = divisor_low_byte;
        end else if (addr == `ADDR_DIV_HIGH && div_access) begin
            next_rd_data = divisor_high_byte;
        end else if (addr == `ADDR_IRQ_IDENTIFY) begin
            // Bit 0 low means pending; only the modem source lives here
            next_rd_data = {4'h0, `IRQ_MODEM_CODE, ~(|deltas)};
        end else if (addr == `ADDR_FRAMING) begin
            next_rd_data = framing_control;
        end else if (addr == `ADDR_LINE_CTRL && !div_access) begin
            next_rd_data = {3'h0, line_control_outputs};
        end else if (addr == `ADDR_STATUS) begin
            next_rd_data = {levels, deltas};
        end else if (addr == `ADDR_SCRATCH) begin
            next_rd_data = scratch_byte;
        end
    end

    // Read data is captured on the strobe and holds until the next read
    always @(posedge clk) begin
        if (srst) begin
            rd_data <= `RESET_BYTE;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end
    end

    // Control outputs lag the control register by one clock
    always @(posedge clk) begin
        if (srst) begin
            dtr_out <= 1'b0;
            rts_out <= 1'b0;
            user_output_one <= 1'b0;
            user_output_two <= 1'b0;
        end else begin
            dtr_out <= line_control_outputs[`CTRL_DTR];
            rts_out <= line_control_outputs[`CTRL_RTS];
            user_output_one <= line_control_outputs[`CTRL_USER_ONE];
            user_output_two <= line_control_outputs[`CTRL_USER_TWO];
        end
    end

    // Interrupt level; drops one cycle after the status read clears the flags
    always @(posedge clk) begin
        if (srst) begin
            modem_irq <= 1'b0;
        end else begin
            modem_irq <= |deltas;
        end
    end
endmodule

/* File: modem_host_port_assertions.sv */
// Checker for host port reads, hidden registers and control outputs
`timescale 1ns/10ps
module modem_host_port_assertions (
    // Watched ports
    input wire clk, input wire srst, input wire [2:0] addr,
    input wire wr_en, input wire rd_en, input wire [7:0] wr_data,
    input wire [7:0] rd_data, input wire dtr_out, input wire rts_out,
    input wire modem_irq
);
    reg div_access;
    reg [7:0] scratch;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Shadow copies, so hidden-register reads need no peeking inside
    always @(posedge clk) begin
        if (srst) begin
            div_access <= 1'b0;
            scratch <= 8'h00;
        end else if (wr_en && addr == 3'h3) begin
            div_access <= wr_data[7];
        end else if (wr_en && addr == 3'h7) begin
            scratch <= wr_data;
        end
    end
    a_read_holds: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved");
    a_unmapped_zero: assert property (rd_en && addr == 3'h5 |=>
        rd_data == 8'h00) else $error("unmapped read");
    a_irq_code: assert property (rd_en && addr == 3'h2 |=>
        rd_data[7:1] == 7'h00) else $error("irq code");
    a_div_hidden: assert property (rd_en && addr[2:1] == 2'b00 &&
        !div_access |=> rd_data == 8'h00) else $error("divisor shown");
    a_ctrl_hidden: assert property (rd_en && addr == 3'h4 &&
        div_access |=> rd_data == 8'h00) else $error("control shown");
    a_scratch_back: assert property (rd_en && addr == 3'h7 |=>
        rd_data == $past(scratch)) else $error("scratch lost");
    a_ctrl_still: assert property (!wr_en && !$past(wr_en) |=>
        $stable({dtr_out, rts_out})) else $error("outputs moved");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=>
        !dtr_out && !rts_out && !modem_irq) else $error("reset leak");
endmodule
bind modem_host_port modem_host_port_assertions chk (.*);

/* File: modem_host_port_test.sv */
// Self-checking bench for the modem host port registers
`timescale 1ns/10ps
module modem_host_port_test;
    logic clk = 1'b0, srst = 1'b1, pend = 1'b0;
    logic dcd_in, ri_in, dsr_in, cts_in;
    wire [2:0] addr;
    wire wr_en, rd_en, dtr_out, rts_out, user_output_one;
    wire user_output_two, modem_irq;
    wire [7:0] wr_data, rd_data;
    logic [7:0] q[$], v, lv[4] = '{8'h22, 8'h11, 8'h40, 8'h88};
    logic [7:0] dc[4] = '{8'h02, 8'h01, 8'h04, 8'h08};
    int n_fail = 0, total_checks = 0, seed = 57537, i;
    host_bus_model host (.*);
    modem_host_port dut (.*);
    initial forever #50 clk = ~clk;
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask
    task report_and_stop;
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Read answers land on the next edge, so compare mid-cycle
    always @(posedge clk) pend <= rd_en;
    always @(negedge clk) if (pend) cmp(rd_data, q.pop_front());
    initial begin
        {dcd_in, ri_in, dsr_in, cts_in} = 4'h0;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        rd(3'h6, 8'h00);
        rd(3'h2, 8'h01);
        rd(3'h5, 8'h00);
        rd(3'h0, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            host.access(1'b1, 3'h7, v);
            rd(3'h7, v);
        end
        host.access(1'b1, 3'h3, 8'h80);
        host.access(1'b1, 3'h0, 8'h17);
        host.access(1'b1, 3'h1, 8'h04);
        rd(3'h0, 8'h17);
        rd(3'h1, 8'h04);
        rd(3'h4, 8'h00);
        host.access(1'b1, 3'h3, 8'h00);
        rd(3'h1, 8'h00);
        // Each control bit alone, looped back and then dropped again
        for (i = 0; i < 4; i++) begin
            host.access(1'b1, 3'h4, 8'h10 | (8'h01 << i));
            repeat (2) @(negedge clk);
            cmp({4'h0, user_output_two, user_output_one, rts_out, dtr_out},
                8'h01 << i);
            rd(3'h6, lv[i]);
            host.access(1'b1, 3'h4, 8'h10);
            repeat (2) @(negedge clk);
            rd(3'h6, dc[i]);
        end
        host.access(1'b1, 3'h4, 8'h00);
        // Random pin rises, then all fall; ring only flags on its fall
        for (i = 0; i < 3; i++) begin
            v = $random(seed);
            {dcd_in, ri_in, dsr_in, cts_in} = v[3:0];
            repeat (5) @(negedge clk);
            cmp({7'h00, modem_irq}, {7'h00, |(v[3:0] & 4'hB)});
            rd(3'h2, {7'h00, ~|(v[3:0] & 4'hB)});
            rd(3'h6, {v[3:0], v[3], 1'b0, v[1:0]});
            {dcd_in, ri_in, dsr_in, cts_in} = 4'h0;
            repeat (5) @(negedge clk);
            rd(3'h6, {4'h0, v[3:0]});
        end
        for (i = 0; i < 20 && q.size() > 0; i++)
            @(negedge clk);
        if (q.size() > 0)
            n_fail++;
        report_and_stop();
    end
endmodule

/* File: modem_regs_map.vh */
// Register offsets, field positions and reset values for the modem host port
`ifndef MODEM_REGS_MAP_VH
`define MODEM_REGS_MAP_VH
`define ADDR_DIV_LOW 3'h0
`define ADDR_DIV_HIGH 3'h1
`define ADDR_IRQ_IDENTIFY 3'h2
`define ADDR_FRAMING 3'h3
`define ADDR_LINE_CTRL 3'h4
`define ADDR_STATUS 3'h6
`define ADDR_SCRATCH 3'h7
`define FRAMING_DIV_ACCESS 7
`define CTRL_DTR 0
`define CTRL_RTS 1
`define CTRL_USER_ONE 2
`define CTRL_USER_TWO 3
`define CTRL_LOOPBACK 4
`define CTRL_WIDTH 5
`define IRQ_MODEM_CODE 3'h0
`define RESET_BYTE 8'h00
`define RESET_CTRL 5'h00
`define RESET_INPUTS 4'h0
`endif
